// ===== sync_defines.svh
// Purpose: named offsets, fields, reset values and counts of the sync block
// Assumes: register byte address is four times the register index
// Notes:   definitions only
`ifndef SYNC_DEFINES_SVH
`define SYNC_DEFINES_SVH

// ----------------------------------------------------------------------
// register indexes and address decode
// ----------------------------------------------------------------------
`define IDX_MODE_CTRL  8'h01
`define IDX_SYNC_CFG   8'h03
`define IDX_IRQ_STAT   8'h09
`define IDX_AUX_CTRL   8'h0a
`define ADDR_HI        11
`define ADDR_IDX_HI    9
`define ADDR_IDX_LO    2

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define MC_PN_EN       13
`define MC_MODE_SEL    12
`define MC_PULSE_EN    11
`define SC_THR_HI      31
`define SC_THR_LO      27
`define SC_IN_EN       26
`define SC_OUT_EN      25
`define SC_IN_DLY_HI   23
`define SC_IN_DLY_LO   19
`define SC_CHK_MODE    18
`define SC_OUT_DLY_HI  15
`define SC_OUT_DLY_LO  11
`define SC_OUT_POL     9
`define SC_CST_HI      7
`define SC_CST_LO      4
`define SC_MARGIN_HI   3
`define SC_MARGIN_LO   0
`define IS_IRQ_EN      0
`define IS_ERR_TYPE    4
`define IS_ERR         6
`define IS_LOCK        10
`define IS_LOST        11
`define IS_CLR_LOCK    12
`define AUX_TX_INV     0

// ----------------------------------------------------------------------
// reset values, code and timing
// ----------------------------------------------------------------------
`define SYNC_CFG_RST   32'h8000_0000
`define PN_CODE        31'h0576_1f29
`define PN_LEN         7'h1f
`define PN_LAST        5'h1e
`define RUN_MAX        4'hf
`define LOCK_TIMEOUT   7'h5d
`define DLY_STEP_PS    80
`define CLK_PERIOD_PS  40000
`define DLY_STEP_CYC   ((`DLY_STEP_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`endif

// ===== sync_pkg.sv
// Purpose: types shared by the sync receiver files
// Assumes: constants live in sync_defines.svh
// Notes:   the delay line, correlator and receiver keep their whole state in one struct from here
package sync_pkg;

    typedef enum logic [1:0] {MODE_OFF, MODE_PULSE, MODE_PN} sync_mode_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_t;

    typedef struct packed {
        logic [31:0] taps;
        logic        out;
    } dly_state_t;

    typedef struct packed {
        logic [30:0] win;
        logic        hit;
    } corr_state_t;

    typedef struct packed {
        apb_rsp_t    rsp;
        logic [31:0] mode_ctrl;
        logic [31:0] sync_cfg;
        logic        tx_inv;
        logic        irq_en;
        logic        err;
        logic        err_type;
        logic        lock;
        logic        lost;
        logic        clr_lock;
        logic        sin_meta;
        logic        sin_sync;
        logic        tx_meta;
        logic        tx_sync;
        logic        tx_prev;
        logic        sd_prev;
        logic [3:0]  run;
        logic        aligned;
        logic [4:0]  cstate;
        logic        init;
        logic        nco_rst;
        logic [4:0]  chip_idx;
        logic        chip_hold;
        logic        sync_out;
        logic        sync_out_en;
        logic [6:0]  lock_cnt;
        logic        irq_n;
    } state_t;

endpackage : sync_pkg

// ===== sync_delay_line.sv
// Purpose: selectable whole-cycle delay of a one-bit stream
// Assumes: one step is rounded up to one clock cycle
// Notes:   total latency is the selected taps plus two cycles
`timescale 1ns/1ns
`include "sync_defines.svh"

module sync_delay_line (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       din,
    input  wire logic [4:0] sel,
    output logic            dout
);
    sync_pkg::dly_state_t s_q;
    sync_pkg::dly_state_t s_d;
    logic [4:0]           tap;

    assign tap  = 5'(32'(sel) * `DLY_STEP_CYC);
    assign dout = s_q.out;

    always_comb begin
        s_d      = s_q;
        s_d.taps = {s_q.taps[30:0], din};
        s_d.out  = s_q.taps[tap];
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule : sync_delay_line

// ===== pn_correlator.sv
// Purpose: sliding correlator that flags a received code period
// Assumes: one chip per clock, code period of 31 chips
// Notes:   hit is a one-cycle pulse, one clock after the last chip
`timescale 1ns/1ns
`include "sync_defines.svh"

module pn_correlator (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       en,
    input  wire logic       chip,
    input  wire logic [4:0] thr,
    output logic            hit
);
    sync_pkg::corr_state_t s_q;
    sync_pkg::corr_state_t s_d;
    logic [30:0]           win_n;
    logic [30:0]           match;
    logic [5:0]            n_match;

    localparam logic [30:0] pn_code = `PN_CODE;

    assign win_n = {s_q.win[29:0], chip};
    assign hit   = s_q.hit;

    generate
        for (genvar i = 0; i < 31; i++) begin : g_match
            assign match[i] = win_n[i] ~^ pn_code[i];
        end
    endgenerate

    always_comb begin
        n_match = '0;
        for (int i = 0; i < 31; i++) begin
            n_match = n_match + 6'(match[i]);
        end
        s_d     = s_q;
        s_d.win = win_n;
        // agreement minus disagreement against threshold; a few bad
        // chips still clear the default, off-peak windows never do
        s_d.hit = en && ({1'b0, n_match} + {1'b0, n_match} >=
                  `PN_LEN + 7'(thr));
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    hit_spacing_a: assert property (@(posedge clk) disable iff (rst)
        hit |=> !hit) else $error("correlator hit lasted two cycles");
endmodule : pn_correlator

// ===== multichip_sync_receiver.sv
// Purpose: multichip sync receiver, pulse and code modes, APB registers
// Assumes: CLOCK is the converter sample clock; strobe pin shares it
// Notes:   delay steps are whole clock cycles at this clock rate
//
// Operation
// - sync input sampled on the sample clock
// - strobe resets oscillator phase after alignment
// - margin shortfall sets sync timing error flag
// - manual error checking when check bit zero
// - four-bit timing margin, zero is smallest
// - input delay field delays sampled sync
// - error reaches interrupt only when enabled
// - writing one clears the error flag
// - error type shows setup or hold
// - master emits code on sync output
// - valid code yields one initialization pulse
// - lock status bit reports code lock
// - lock lost latched, cleared by one-zero write
// - output delay field delays emitted code
// - polarity bit delays emitted code further
// - threshold sets chips needed for lock
// - isolated bad chips do not break lock
// - init pulse loads programmed clock state
// - each increment advances clocks one period
// - pulse mode init on sync rising edge
// - flags latched; active-low interrupt while unmasked
`timescale 1ns/1ns
`include "sync_defines.svh"

module multichip_sync_receiver (
    input  wire logic        CLOCK,
    input  wire logic        RST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        SYNC_IN,
    input  wire logic        TRANSMIT_ENABLE_STROBE,
    output logic             SYNC_OUT,
    output logic             SYNC_OUT_EN,
    output logic             IRQ_N,
    output logic      [4:0]  CLOCK_PHASE,
    output logic             INIT_PULSE,
    output logic             NCO_PHASE_RESET
);
    // ------------------------------------------------------------------
    // state and decode
    // ------------------------------------------------------------------
    sync_pkg::state_t     s_q;
    sync_pkg::state_t     s_d;
    sync_pkg::sync_mode_t mode;
    logic [7:0]           idx;
    logic                 up_ok;
    logic                 mapped;
    logic                 wr;
    logic                 clr_err_w;
    logic                 sd;
    logic                 edge_seen;
    logic                 rise;
    logic                 hit;
    logic                 tx_lvl;
    logic                 tx_fall;
    logic                 chk_on;
    logic                 err_ev;
    logic                 master;
    logic                 chip;
    logic                 out_dly;
    logic [4:0]           chip_pos;

    localparam logic [30:0] pn_code = `PN_CODE;

    assign idx    = PADDR[`ADDR_IDX_HI:`ADDR_IDX_LO];
    assign up_ok  = (PADDR[`ADDR_HI:`ADDR_IDX_HI+1] == '0) &&
                    (PADDR[`ADDR_IDX_LO-1:0] == '0);
    assign mapped = up_ok && (idx == `IDX_MODE_CTRL ||
                    idx == `IDX_SYNC_CFG || idx == `IDX_IRQ_STAT ||
                    idx == `IDX_AUX_CTRL);
    // a write lands on the edge where the master sees pready high
    assign wr        = PSEL && PENABLE && PWRITE && s_q.rsp.pready;
    assign clr_err_w = wr && mapped && idx == `IDX_IRQ_STAT &&
                       PWDATA[`IS_ERR];

    // mode bits as software sets them; anything else leaves sync off
    always_comb begin
        if (s_q.mode_ctrl[`MC_PN_EN] && s_q.mode_ctrl[`MC_MODE_SEL] &&
            !s_q.mode_ctrl[`MC_PULSE_EN] && s_q.sync_cfg[`SC_IN_EN]) begin
            mode = sync_pkg::MODE_PN;
        end else if (!s_q.mode_ctrl[`MC_PN_EN] &&
                     !s_q.mode_ctrl[`MC_MODE_SEL] &&
                     s_q.mode_ctrl[`MC_PULSE_EN] &&
                     s_q.sync_cfg[`SC_IN_EN]) begin
            mode = sync_pkg::MODE_PULSE;
        end else begin
            mode = sync_pkg::MODE_OFF;
        end
    end

    // ------------------------------------------------------------------
    // sync input path
    // ------------------------------------------------------------------
    sync_delay_line u_in_dly (
        .clk  (CLOCK),
        .rst  (RST),
        .din  (s_q.sin_sync),
        .sel  (s_q.sync_cfg[`SC_IN_DLY_HI:`SC_IN_DLY_LO]),
        .dout (sd)
    );

    assign edge_seen = sd ^ s_q.sd_prev;
    assign rise      = sd && !s_q.sd_prev;

    pn_correlator u_corr (
        .clk  (CLOCK),
        .rst  (RST),
        .en   (mode == sync_pkg::MODE_PN),
        .chip (sd),
        .thr  (s_q.sync_cfg[`SC_THR_HI:`SC_THR_LO]),
        .hit  (hit)
    );

    // ------------------------------------------------------------------
    // code generation on the master
    // ------------------------------------------------------------------
    assign master   = mode == sync_pkg::MODE_PN &&
                      s_q.sync_cfg[`SC_OUT_EN];
    assign chip_pos = `PN_LAST - s_q.chip_idx;
    assign chip     = pn_code[chip_pos];

    sync_delay_line u_out_dly (
        .clk  (CLOCK),
        .rst  (RST),
        .din  (chip),
        .sel  (s_q.sync_cfg[`SC_OUT_DLY_HI:`SC_OUT_DLY_LO]),
        .dout (out_dly)
    );

    // ------------------------------------------------------------------
    // strobe and timing checks
    // ------------------------------------------------------------------
    // the idle level is high; the inversion bit flips the pulse sense
    assign tx_lvl  = s_q.tx_sync ^ s_q.tx_inv;
    assign tx_fall = s_q.tx_prev && !tx_lvl;
    assign chk_on  = mode != sync_pkg::MODE_OFF &&
                     !s_q.sync_cfg[`SC_CHK_MODE];
    // run counts stable cycles before a change: low run guards setup,
    // high run guards hold; margin zero can never fail
    assign err_ev  = chk_on && edge_seen &&
                     s_q.run <= s_q.sync_cfg[`SC_MARGIN_HI:`SC_MARGIN_LO];

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        logic [31:0] rd;
        rd  = '0;
        s_d = s_q;

        s_d.sin_meta = SYNC_IN;
        s_d.sin_sync = s_q.sin_meta;
        s_d.tx_meta  = TRANSMIT_ENABLE_STROBE;
        s_d.tx_sync  = s_q.tx_meta;
        s_d.tx_prev  = tx_lvl;
        s_d.sd_prev  = sd;

        if (edge_seen) begin
            s_d.run = 4'h1;
        end else if (s_q.run != `RUN_MAX) begin
            s_d.run = s_q.run + 4'h1;
        end

        // clock generation state machine
        s_d.init = (mode == sync_pkg::MODE_PULSE && rise) ||
                   (mode == sync_pkg::MODE_PN && hit);
        if (s_q.init) begin
            s_d.cstate = {1'b0, s_q.sync_cfg[`SC_CST_HI:`SC_CST_LO]};
        end else begin
            s_d.cstate = s_q.cstate + 5'h1;
        end
        if (mode == sync_pkg::MODE_OFF) begin
            s_d.aligned = 1'b0;
        end else if (s_q.init) begin
            s_d.aligned = 1'b1;
        end
        s_d.nco_rst = (mode == sync_pkg::MODE_PULSE && s_q.aligned &&
                       tx_fall) ||
                      (mode == sync_pkg::MODE_PN && hit);

        // code output; the half period is rounded to one whole cycle
        if (s_q.chip_idx == `PN_LAST) begin
            s_d.chip_idx = '0;
        end else begin
            s_d.chip_idx = s_q.chip_idx + 5'h1;
        end
        s_d.chip_hold   = out_dly;
        s_d.sync_out    = master && (s_q.sync_cfg[`SC_OUT_POL] ?
                          s_q.chip_hold : out_dly);
        s_d.sync_out_en = master;

        // register access
        if (up_ok) begin
            case (idx)
                `IDX_MODE_CTRL: rd = s_q.mode_ctrl;
                `IDX_SYNC_CFG:  rd = s_q.sync_cfg;
                `IDX_IRQ_STAT: begin
                    rd[`IS_IRQ_EN]   = s_q.irq_en;
                    rd[`IS_ERR_TYPE] = s_q.err_type;
                    rd[`IS_ERR]      = s_q.err;
                    rd[`IS_LOCK]     = s_q.lock;
                    rd[`IS_LOST]     = s_q.lost;
                    rd[`IS_CLR_LOCK] = s_q.clr_lock;
                end
                `IDX_AUX_CTRL:  rd[`AUX_TX_INV] = s_q.tx_inv;
                default:        rd = '0;
            endcase
        end
        s_d.rsp = '0;
        if (PSEL && PENABLE && !s_q.rsp.pready) begin
            s_d.rsp.pready  = 1'b1;
            s_d.rsp.pslverr = !mapped;
            if (!PWRITE) begin
                s_d.rsp.prdata = rd;
            end
        end
        if (wr && mapped) begin
            case (idx)
                `IDX_MODE_CTRL: s_d.mode_ctrl = PWDATA;
                `IDX_SYNC_CFG:  s_d.sync_cfg  = PWDATA;
                `IDX_IRQ_STAT: begin
                    s_d.irq_en   = PWDATA[`IS_IRQ_EN];
                    s_d.clr_lock = PWDATA[`IS_CLR_LOCK];
                    if (PWDATA[`IS_ERR]) begin
                        s_d.err = 1'b0;
                    end
                end
                `IDX_AUX_CTRL:  s_d.tx_inv = PWDATA[`AUX_TX_INV];
                default:        s_d.tx_inv = s_q.tx_inv;
            endcase
        end
        if (s_q.clr_lock && !s_d.clr_lock) begin
            s_d.lost = 1'b0;
        end

        // hardware events come last so a set beats a same-cycle clear
        if (err_ev) begin
            s_d.err      = 1'b1;
            s_d.err_type = !sd;
        end
        if (mode != sync_pkg::MODE_PN) begin
            s_d.lock     = 1'b0;
            s_d.lock_cnt = '0;
        end else if (hit) begin
            s_d.lock     = 1'b1;
            s_d.lock_cnt = '0;
        end else if (s_q.lock) begin
            // three missed periods before giving lock up
            if (s_q.lock_cnt == `LOCK_TIMEOUT) begin
                s_d.lock = 1'b0;
                s_d.lost = 1'b1;
            end else begin
                s_d.lock_cnt = s_q.lock_cnt + 7'h1;
            end
        end
        s_d.irq_n = !(s_q.err && s_q.irq_en);
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            s_q          <= '0;
            s_q.sync_cfg <= `SYNC_CFG_RST;
            s_q.irq_n    <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign PRDATA          = s_q.rsp.prdata;
    assign PREADY          = s_q.rsp.pready;
    assign PSLVERR         = s_q.rsp.pslverr;
    assign SYNC_OUT        = s_q.sync_out;
    assign SYNC_OUT_EN     = s_q.sync_out_en;
    assign IRQ_N           = s_q.irq_n;
    assign CLOCK_PHASE     = s_q.cstate;
    assign INIT_PULSE      = s_q.init;
    assign NCO_PHASE_RESET = s_q.nco_rst;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);

    sequence apb_setup_s;
        PSEL && !PENABLE;
    endsequence
    sequence apb_access_s;
        PSEL && PENABLE && !PREADY;
    endsequence
    sequence lock_drop_s;
        s_q.lock ##1 !s_q.lock && mode == sync_pkg::MODE_PN;
    endsequence

    init_on_rise_a: assert property (
        mode == sync_pkg::MODE_PULSE && rise |=> INIT_PULSE)
        else $error("no init pulse after sync rising edge");
    held_high_a: assert property (
        mode == sync_pkg::MODE_PULSE && sd && s_q.sd_prev |=> !INIT_PULSE)
        else $error("init pulse while sync held high");
    state_load_a: assert property (
        INIT_PULSE |=> CLOCK_PHASE ==
        {1'b0, $past(s_q.sync_cfg[`SC_CST_HI:`SC_CST_LO])})
        else $error("clock state not loaded on init pulse");
    state_advance_a: assert property (
        !INIT_PULSE |=> CLOCK_PHASE == 5'($past(CLOCK_PHASE) + 5'h1))
        else $error("clock state did not advance by one");
    err_set_a: assert property (err_ev |=> s_q.err)
        else $error("timing error event not latched");
    err_sticky_a: assert property (
        s_q.err && !clr_err_w |=> s_q.err)
        else $error("error flag dropped without a clear");
    err_clear_a: assert property (clr_err_w && !err_ev |=> !s_q.err)
        else $error("error flag not cleared by write one");
    irq_route_a: assert property (
        s_q.err && s_q.irq_en ##1 1'b1 |-> !IRQ_N)
        else $error("unmasked error did not assert interrupt");
    irq_masked_a: assert property (!s_q.irq_en |=> IRQ_N)
        else $error("masked error asserted interrupt");
    lock_lost_a: assert property (lock_drop_s |-> s_q.lost)
        else $error("lock loss not latched");
    code_lock_a: assert property (
        mode == sync_pkg::MODE_PN && hit |=> INIT_PULSE && s_q.lock)
        else $error("valid code did not init and lock");
    nco_reset_a: assert property (
        mode == sync_pkg::MODE_PULSE && s_q.aligned && tx_fall
        |=> NCO_PHASE_RESET)
        else $error("strobe did not reset phase accumulators");
    apb_wait_a: assert property (apb_setup_s ##1 apb_access_s |=> PREADY)
        else $error("apb answer not given after one wait cycle");
endmodule : multichip_sync_receiver

// ===== sync_source.sv
// Purpose: far side of the sync pins, pulse source or code loopback
// Assumes: shares the receiver clock
// Notes:   strobe idles high and pulses low; flip inverts the strobe and the looped-back code, not the pulse
`timescale 1ns/1ns

module sync_source (
    input  wire logic clk,
    input  wire logic pulse_on,
    input  wire logic loop_on,
    input  wire logic flip,
    input  wire logic stb_req,
    input  wire logic code_in,
    output logic      sync_pin,
    output logic      strobe_pin
);
    logic [4:0] cnt_q = 5'h00;

    // 32-cycle period: a rate of sample clock over sixteen times two
    always_ff @(posedge clk) begin
        cnt_q      <= cnt_q + 5'h01;
        strobe_pin <= ~stb_req ^ flip;
        if (loop_on) begin
            sync_pin <= code_in ^ flip;
        end else begin
            sync_pin <= pulse_on & cnt_q[4];
        end
    end
endmodule : sync_source

// ===== multichip_sync_receiver_tb_top.sv
// Purpose: register and pin tests of the sync receiver
// Assumes: master waits for pready, however late it comes
// Notes:   pulse, strobe, timing error and code lock scenarios
`timescale 1ns/1ns

`define CHK(g, e) begin \
    checks_done++; \
    if ((g) !== (e)) begin \
        mismatches++; \
        $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); \
    end \
end

module multichip_sync_receiver_tb_top;
    logic        clk;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        sync_in;
    logic        strobe;
    logic        sync_out;
    logic        out_en;
    logic        irq_n;
    logic [4:0]  phase;
    logic        init;
    logic        nco_rst;
    logic        pulse_on = 1'b0;
    logic        loop_on = 1'b0;
    logic        flip = 1'b0;
    logic        stb_req = 1'b0;
    logic [31:0] rd;
    logic        er;
    int          mismatches = 0;
    int          checks_done = 0;
    int          cyc = 0;

    multichip_sync_receiver u_multichip_sync_receiver (
        .CLOCK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .SYNC_IN(sync_in), .TRANSMIT_ENABLE_STROBE(strobe),
        .SYNC_OUT(sync_out), .SYNC_OUT_EN(out_en), .IRQ_N(irq_n),
        .CLOCK_PHASE(phase), .INIT_PULSE(init),
        .NCO_PHASE_RESET(nco_rst));

    sync_source u_sync_source (
        .clk(clk), .pulse_on(pulse_on), .loop_on(loop_on), .flip(flip),
        .stb_req(stb_req), .code_in(sync_out), .sync_pin(sync_in),
        .strobe_pin(strobe));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic summarize();
        $display("checks=%0d mismatches=%0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : summarize

    // a hung handshake ends here
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            summarize();
        end
    end

    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic wait_hi(input logic nco, input int lim);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while ((nco ? nco_rst : init) !== 1'b1 && n < lim);
        `CHK(n < lim, 1'b1)
    endtask : wait_hi

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        xfer(1'b0, 12'h00c, 32'h0);
        `CHK(rd, 32'h8000_0000)
        xfer(1'b0, 12'h010, 32'h0);
        `CHK({er, rd}, 33'h1_0000_0000)
        xfer(1'b1, 12'h004, 32'h0000_0800);
        xfer(1'b1, 12'h00c, 32'h8400_0450);
        xfer(1'b1, 12'h024, 32'h0000_0001);
        pulse_on <= 1'b1;
        wait_hi(1'b0, 80);
        @(negedge clk);
        `CHK(phase, 5'h05)
        repeat (2) @(negedge clk);
        `CHK(phase, 5'h07)
        repeat (29) @(negedge clk);
        `CHK(init, 1'b1)
        @(negedge clk);
        `CHK(init, 1'b0)
        xfer(1'b1, 12'h00c, 32'h8418_0450);
        repeat (50) @(negedge clk);
        `CHK(5'(phase - u_sync_source.cnt_q), 5'h0b)
        xfer(1'b0, 12'h024, 32'h0);
        `CHK(rd[6], 1'b0)
        stb_req <= 1'b1;
        @(posedge clk);
        stb_req <= 1'b0;
        wait_hi(1'b1, 10);
        @(posedge clk);
        flip <= 1'b1;
        xfer(1'b1, 12'h028, 32'h0000_0001);
        repeat (4) @(posedge clk);
        stb_req <= 1'b1;
        wait_hi(1'b1, 6);
        @(posedge clk);
        stb_req <= 1'b0;
        xfer(1'b1, 12'h028, 32'h0);
        flip <= 1'b0;
        xfer(1'b1, 12'h00c, 32'h8400_045f);
        repeat (40) @(posedge clk);
        xfer(1'b0, 12'h024, 32'h0);
        `CHK(rd[6], 1'b1)
        `CHK(irq_n, 1'b0)
        xfer(1'b1, 12'h00c, 32'h8404_045f);
        xfer(1'b1, 12'h024, 32'h0000_0041);
        repeat (40) @(posedge clk);
        xfer(1'b0, 12'h024, 32'h0);
        `CHK(rd[6], 1'b0)
        `CHK(irq_n, 1'b1)
        xfer(1'b1, 12'h00c, 32'h8400_045f);
        repeat (40) @(posedge clk);
        pulse_on <= 1'b0;
        repeat (40) @(posedge clk);
        xfer(1'b1, 12'h024, 32'h0);
        repeat (2) @(negedge clk);
        `CHK(irq_n, 1'b1)
        xfer(1'b0, 12'h024, 32'h0);
        `CHK(rd[6:4], 3'h5)
        xfer(1'b1, 12'h024, 32'h0000_0040);
        xfer(1'b0, 12'h024, 32'h0);
        `CHK(rd[6], 1'b0)
        xfer(1'b1, 12'h004, 32'h0000_3000);
        xfer(1'b1, 12'h00c, 32'h8600_0400);
        loop_on <= 1'b1;
        repeat (5) @(negedge clk);
        `CHK(out_en, 1'b1)
        repeat (200) @(posedge clk);
        wait_hi(1'b0, 40);
        @(posedge clk);
        flip <= 1'b1;
        @(posedge clk);
        flip <= 1'b0;
        repeat (100) @(posedge clk);
        xfer(1'b0, 12'h024, 32'h0);
        `CHK(rd[11:10], 2'h1)
        loop_on <= 1'b0;
        repeat (200) @(posedge clk);
        xfer(1'b0, 12'h024, 32'h0);
        `CHK(rd[11:10], 2'h2)
        xfer(1'b1, 12'h024, 32'h0000_1000);
        xfer(1'b1, 12'h024, 32'h0);
        xfer(1'b0, 12'h024, 32'h0);
        `CHK(rd[11], 1'b0)
        summarize();
    end
endmodule : multichip_sync_receiver_tb_top
